// file: shared/pac_regs.svh
// register offsets, field positions, reset values and counts of the arbiter
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH

// byte addresses of the registers on the wishbone bus
`define PAC_ADDR_CONFIG      16'hd104
`define PAC_ADDR_STATUS      16'hd108
`define PAC_ADDR_IRQ_MASK    16'hd10c
`define PAC_ADDR_FLAGS       16'hd110

// arbiter_config field positions
`define PAC_CFG_FIXED_PARK   3
`define PAC_CFG_SOFT_RESET   2
`define PAC_CFG_ENABLE       1
`define PAC_CFG_CHECK_EN     0

// arbiter_status and arbiter_irq_mask field positions
`define PAC_STAT_DETECTED    0
`define PAC_MASK_IRQ_EN      0

// reset values
`define PAC_CFG_RESET        4'h0
`define PAC_STAT_RESET       1'b0
`define PAC_MASK_RESET       1'b0
`define PAC_FLAGS_RESET      8'h00

// request port codes
`define PAC_CODE_CTRL        3'h7
`define PAC_CODE_EXT_MAX     3'h3

// logical master a sits at index 7, z at index 0
`define PAC_IDX_A            3'h7

// idle-grant cycles before a requesting master is judged broken
`define PAC_BROKEN_CYC       5'h10

`endif

// file: shared/pac_pkg.sv
// types shared by the arbiter control files
package pac_pkg;

  // grant state of the arbitration core
  typedef enum logic [1:0] {
    st_idle,
    st_grant,
    st_own
  } pac_state_e;

  // one bit per logical master, a at bit 7 down to z at bit 0
  typedef logic [7:0] pac_vec_t;

  // index of one logical master
  typedef logic [2:0] pac_idx_t;

endpackage : pac_pkg

// file: src/pac_arb_core.sv
// arbitration core: round robin grant, parking and broken master timing
`timescale 1ns/100ps
`default_nettype none
`include "pac_regs.svh"

module pac_arb_core (
  // clock and arbiter reset (chip reset or soft reset)
  input  wire logic          clk_i,
  input  wire logic          arb_rst_i,
  // logical requests and arbitration permissions
  input  wire logic [7:0]    req_i,
  input  wire logic [7:0]    allow_i,
  input  wire logic          bus_busy_i,
  // configuration
  input  wire logic          fixed_park_i,
  input  wire logic          check_en_i,
  input  wire logic [2:0]    ctrl_idx_i,
  input  wire logic          ctrl_ok_i,
  // logical grants and broken detection pulses
  output logic [7:0]         gnt_o,
  output logic [7:0]         broken_o
);

  pac_pkg::pac_state_e state_q;
  pac_pkg::pac_idx_t   cur_q;
  pac_pkg::pac_idx_t   last_q;
  logic                last_ok_q;
  logic [4:0]          cnt_q;
  logic [3:0]          pick;
  pac_pkg::pac_idx_t   park_idx;
  logic                park_ok;
  logic                timeout_hit;

  // round robin: the first requester after the last owner wins
  function automatic logic [3:0] pick_next(input logic [7:0] req,
                                           input logic [2:0] last);
    logic [3:0] res;
    logic [2:0] cand;
    integer     i;
    res = 4'h0;
    for (i = 8; i >= 1; i = i - 1) begin
      cand = 3'(last + i[2:0]);
      if (req[cand]) begin
        res = {1'b1, cand};
      end
    end
    return res;
  endfunction : pick_next

  // park target: master a when fixed, else last owner, else controller
  always_comb begin
    // a master that timed out last cycle waits out the edge its flag lands
    pick = pick_next(req_i & allow_i & ~broken_o, last_q); // see RQ10
    if (fixed_park_i) begin
      park_idx = `PAC_IDX_A; // see RQ1
    end else if (last_ok_q) begin
      park_idx = last_q; // see RQ1
    end else begin
      park_idx = ctrl_idx_i; // see RQ5
    end
    park_ok = (fixed_park_i | last_ok_q | ctrl_ok_i) & allow_i[park_idx] &
              ~broken_o[park_idx];
    timeout_hit = (state_q == pac_pkg::st_grant) & allow_i[cur_q] &
                  ~bus_busy_i & req_i[cur_q] & check_en_i &
                  (cnt_q == `PAC_BROKEN_CYC - 5'h01); // see RQ6
  end

  // grant state machine; a grant is always dropped for a cycle on handover
  always_ff @(posedge clk_i) begin
    if (arb_rst_i) begin // see RQ2
      state_q <= pac_pkg::st_idle;
      gnt_o   <= 8'h00;
      cur_q   <= 3'h0;
      cnt_q   <= 5'h00;
    end else begin
      case (state_q)
        pac_pkg::st_idle: begin
          cnt_q <= 5'h00;
          if (!bus_busy_i && pick[3]) begin
            gnt_o   <= 8'h01 << pick[2:0];
            cur_q   <= pick[2:0];
            state_q <= pac_pkg::st_grant;
          end else if (!bus_busy_i && park_ok) begin
            gnt_o   <= 8'h01 << park_idx;
            cur_q   <= park_idx;
            state_q <= pac_pkg::st_grant;
          end
        end
        pac_pkg::st_grant: begin
          if (!allow_i[cur_q] || timeout_hit) begin // see RQ10
            gnt_o   <= 8'h00;
            state_q <= pac_pkg::st_idle;
          end else if (bus_busy_i) begin
            state_q <= pac_pkg::st_own;
          end else if (!req_i[cur_q] &&
                       (pick[3] || (park_ok && park_idx != cur_q))) begin
            // an idle master yields to a requester or a new park target,
            // so a change of the fixed park bit takes effect at once
            gnt_o   <= 8'h00; // see RQ1
            state_q <= pac_pkg::st_idle;
          end else if (req_i[cur_q]) begin
            cnt_q <= 5'(cnt_q + 5'h01);
          end else begin
            cnt_q <= 5'h00;
          end
        end
        pac_pkg::st_own: begin
          if (!bus_busy_i) begin
            gnt_o   <= 8'h00;
            state_q <= pac_pkg::st_idle;
          end else if (pick[3] && pick[2:0] != cur_q) begin
            gnt_o <= 8'h00; // owner finishes, next one waits for idle
          end
        end
        default: begin
          state_q <= pac_pkg::st_idle;
        end
      endcase
    end
  end

  // last owner: the master that actually started a transaction
  always_ff @(posedge clk_i) begin
    if (arb_rst_i) begin
      last_q    <= 3'h0;
      last_ok_q <= 1'b0;
    end else if (state_q == pac_pkg::st_grant && allow_i[cur_q] &&
                 !timeout_hit && bus_busy_i) begin
      last_q    <= cur_q; // see RQ1
      last_ok_q <= 1'b1;
    end
  end

  // one pulse on the master that let an idle grant time out
  always_ff @(posedge clk_i) begin
    if (arb_rst_i) begin
      broken_o <= 8'h00;
    end else begin
      broken_o <= timeout_hit ? (8'h01 << cur_q) : 8'h00; // see RQ9
    end
  end

endmodule : pac_arb_core
`default_nettype wire

// file: src/pac_arbiter.sv
// bus arbiter control and status: registers, request mapping, grants, irq
//
// How it works
// RQ1 - fixed park bit 0 parks on last owner; 1 parks on port a
// RQ2 - soft reset bit holds arbiter in reset, registers keep their values
// RQ3 - soft reset never clears itself; software writes 0 to release it
// RQ4 - external requests ignored until enable bit set; 0 disables them
// RQ5 - after reset the internal controller is the parking master
// RQ6 - no new broken flag unless check enable is 1
// RQ7 - status bit reads 1 while any broken flag is 1; write 1 clears
// RQ8 - interrupt raised on broken detection only when irq enable is 1
// RQ9 - with checking on, broken masters get their own flag set
// RQ10 - any set broken flag, even software written, excludes that master
// RQ11 - software clears all broken flags after changing the port mapping
// RQ12 - broken flags bits 7..0 belong to masters a,b,c,d,w,x,y,z
// RQ13 - all control, status and broken bits reset to 0
// RQ14 - 3-bit port code: 111 controller, 000..011 request lines 0..3
// RQ15 - irq is status and enable; reserved bits read zero
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pac_regs.svh"

module pac_arbiter (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // classic wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [15:0]   wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // internal controller request and grant
  input  wire logic          int_req_i,
  output logic               int_gnt_o,
  // external request and grant pins, active low
  input  wire logic [3:0]    ext_req_n_i,
  output logic [3:0]         ext_gnt_n_o,
  // bus activity pins, active low
  input  wire logic          frame_n_i,
  input  wire logic          irdy_n_i,
  // request port mapping, held by the mapping register
  input  wire logic [31:0]   request_port_map_i,
  // interrupt
  output logic               irq_o
);

  // software visible state
  logic [3:0]        cfg_q;
  logic              stat_q;
  logic              mask_q;
  pac_pkg::pac_vec_t flags_q;

  // bus slave internals
  logic              ack_q;
  logic [15:0]       word_adr;
  logic              hit_cfg;
  logic              hit_stat;
  logic              hit_mask;
  logic              hit_flags;
  logic              wr_go;
  logic [31:0]       rd_data;

  // pin synchronisers
  logic [3:0]        ext_req_m_q;
  logic [3:0]        ext_req_s_q;
  logic [1:0]        bus_m_q;
  logic [1:0]        bus_s_q;
  logic              bus_busy;

  // mapping and core connections
  pac_pkg::pac_vec_t log_req;
  pac_pkg::pac_vec_t allow;
  pac_pkg::pac_vec_t log_gnt;
  pac_pkg::pac_vec_t broken;
  pac_pkg::pac_idx_t ctrl_idx;
  logic              ctrl_ok;
  logic              int_gnt_d;
  logic [3:0]        ext_gnt_d;
  logic              arb_rst;

  // port code to target: bit 4 is the controller, bits 3..0 the lines
  function automatic logic [4:0] code_sel(input logic [2:0] code);
    logic [4:0] res;
    res = 5'h00;
    if (code == `PAC_CODE_CTRL) begin
      res = 5'h10; // see RQ14
    end else if (code <= `PAC_CODE_EXT_MAX) begin
      res = {1'b0, 4'h1 << code[1:0]}; // see RQ14
    end
    return res;
  endfunction : code_sel

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------

  // decode on the word address; sub-word address bits are ignored
  always_comb begin
    word_adr  = {wb_adr_i[15:2], 2'b00};
    hit_cfg   = 1'b0;
    hit_stat  = 1'b0;
    hit_mask  = 1'b0;
    hit_flags = 1'b0;
    if (word_adr == `PAC_ADDR_CONFIG) begin
      hit_cfg = 1'b1;
    end else if (word_adr == `PAC_ADDR_STATUS) begin
      hit_stat = 1'b1;
    end else if (word_adr == `PAC_ADDR_IRQ_MASK) begin
      hit_mask = 1'b1;
    end else if (word_adr == `PAC_ADDR_FLAGS) begin
      hit_flags = 1'b1;
    end
  end

  // a write lands on the edge where the master sees ack; only the low
  // byte lane carries defined bits, so only sel[0] enables a write
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

  // read mux; reserved bits and unmapped words read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_cfg) begin
      rd_data[3:0] = cfg_q; // see RQ15
    end else if (hit_stat) begin
      rd_data[`PAC_STAT_DETECTED] = stat_q;
    end else if (hit_mask) begin
      rd_data[`PAC_MASK_IRQ_EN] = mask_q;
    end else if (hit_flags) begin
      rd_data[7:0] = flags_q; // see RQ12
    end
  end

  // ack one cycle after the strobe, dropped the cycle after that
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      ack_q    <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~ack_q;
      ack_q    <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // read data is captured as ack rises and held while it stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // configuration; the soft reset bit stays until software clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `PAC_CFG_RESET; // see RQ13
    end else if (wr_go && hit_cfg) begin
      cfg_q <= wb_dat_i[3:0]; // see RQ3
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= `PAC_MASK_RESET; // see RQ13
    end else if (wr_go && hit_mask) begin
      mask_q <= wb_dat_i[`PAC_MASK_IRQ_EN];
    end
  end

  // broken flags: software may write any value, a detection in the
  // same cycle still sets its bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= `PAC_FLAGS_RESET; // see RQ13
    end else if (wr_go && hit_flags) begin
      flags_q <= wb_dat_i[7:0] | broken; // see RQ9
    end else begin
      flags_q <= flags_q | broken; // see RQ9
    end
  end

  // summary status: write 1 clears, but any set flag sets it again,
  // so it cannot be cleared while a flag stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `PAC_STAT_RESET; // see RQ13
    end else begin
      stat_q <= (stat_q & ~(wr_go & hit_stat &
                 wb_dat_i[`PAC_STAT_DETECTED])) | (|flags_q); // see RQ7
    end
  end

  // level interrupt while status and enable are both set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= stat_q & mask_q; // see RQ8 see RQ15
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------

  // two flops on every asynchronous pin before any logic looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_req_m_q <= 4'hf;
      ext_req_s_q <= 4'hf;
      bus_m_q     <= 2'h3;
      bus_s_q     <= 2'h3;
    end else begin
      ext_req_m_q <= ext_req_n_i;
      ext_req_s_q <= ext_req_m_q;
      bus_m_q     <= {frame_n_i, irdy_n_i};
      bus_s_q     <= bus_m_q;
    end
  end

  // bus counts as busy while either frame or irdy is low
  assign bus_busy = ~(&bus_s_q);

  // ---------------------------------------------------------------
  // mapping of logical masters to physical requesters
  // ---------------------------------------------------------------

  // logical requests; external lines stay blind until enabled, the
  // controller is always heard
  always_comb begin
    logic [4:0] sel;
    integer     k;
    sel      = 5'h00;
    log_req  = 8'h00;
    ctrl_idx = 3'h0;
    ctrl_ok  = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      sel = code_sel(request_port_map_i[k*4 +: 3]);
      if (sel[4]) begin
        log_req[k] = int_req_i;
        ctrl_idx   = k[2:0]; // see RQ5
        ctrl_ok    = 1'b1;
      end else begin
        log_req[k] = cfg_q[`PAC_CFG_ENABLE] &
                     (|(sel[3:0] & ~ext_req_s_q)); // see RQ4
      end
    end
  end

  // a flagged master takes no part in arbitration, checking on or off
  assign allow = ~flags_q; // see RQ10 see RQ11

  // arbiter reset is the chip reset or the soft reset bit
  assign arb_rst = rst_i | cfg_q[`PAC_CFG_SOFT_RESET]; // see RQ2

  // arbitration core
  pac_arb_core u_core (
    .clk_i        (clk_i),
    .arb_rst_i    (arb_rst),
    .req_i        (log_req),
    .allow_i      (allow),
    .bus_busy_i   (bus_busy),
    .fixed_park_i (cfg_q[`PAC_CFG_FIXED_PARK]),
    .check_en_i   (cfg_q[`PAC_CFG_CHECK_EN]),
    .ctrl_idx_i   (ctrl_idx),
    .ctrl_ok_i    (ctrl_ok),
    .gnt_o        (log_gnt),
    .broken_o     (broken)
  );

  // logical grants back onto physical grant signals; reserved codes
  // reach nobody, so a master on one is never granted
  always_comb begin
    logic [4:0] sel;
    integer     k;
    sel       = 5'h00;
    int_gnt_d = 1'b0;
    ext_gnt_d = 4'h0;
    for (k = 0; k < 8; k = k + 1) begin
      sel = code_sel(request_port_map_i[k*4 +: 3]);
      if (log_gnt[k]) begin
        int_gnt_d = int_gnt_d | sel[4]; // see RQ14
        ext_gnt_d = ext_gnt_d | sel[3:0];
      end
    end
  end

  // registered grant outputs, all released during any reset
  always_ff @(posedge clk_i) begin
    if (arb_rst) begin
      int_gnt_o   <= 1'b0;
      ext_gnt_n_o <= 4'hf;
    end else begin
      int_gnt_o   <= int_gnt_d;
      ext_gnt_n_o <= ~ext_gnt_d;
    end
  end

endmodule : pac_arbiter
`default_nettype wire

// file: dv/pac_pci_masters.sv
// behavioural pci masters standing behind the four external request lines
`timescale 1ns/100ps
`default_nettype none

module pac_pci_masters (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bench commands: lines that want the bus, and a master that never starts
  input  wire logic [3:0] want_i,
  input  wire logic       broken_i,
  // bus pins
  input  wire logic [3:0] ext_gnt_n_i,
  output logic [3:0]      ext_req_n_o,
  output logic            frame_n_o,
  output logic            irdy_n_o
);
  logic [1:0] phase_q;

  // REQ# follows pending work; FRAME# and IRDY# are driven high from phase_q when idle
  assign ext_req_n_o = ~want_i;
  assign frame_n_o   = (phase_q != 2'h3);
  assign irdy_n_o    = (phase_q < 2'h2);

  // one data phase on own grant; a stuck master leaves the bus idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 2'h0;
    end else if (phase_q != 2'h0) begin
      phase_q <= phase_q - 2'h1;
    end else if (!broken_i && (|(want_i & ~ext_gnt_n_i))) begin
      phase_q <= 2'h3;
    end
  end
endmodule : pac_pci_masters

`default_nettype wire

// file: dv/pac_arbiter_checker.sv
// concurrent checks on the arbiter ports, bound into the design
`timescale 1ns/100ps
`default_nettype none
`include "pac_regs.svh"

module pac_arbiter_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // grants and interrupt
  input wire logic        int_gnt_o,
  input wire logic [3:0]  ext_gnt_n_o,
  input wire logic        irq_o
);
  logic [3:0]  cfg_q;
  logic        mask_q;
  logic        en_seen_q;
  logic [31:0] ok_bits;
  logic [15:0] word;
  logic [4:0]  gvec;
  logic        wr;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // grant view with the controller on top, all active high
  assign gvec = {int_gnt_o, ~ext_gnt_n_o};
  assign word = {wb_adr_i[15:2], 2'b00};
  assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

  // bits a read may carry
  always_comb begin
    case (word)
      `PAC_ADDR_CONFIG:   ok_bits = 32'h0000_000f;
      `PAC_ADDR_STATUS:   ok_bits = 32'h0000_0001;
      `PAC_ADDR_IRQ_MASK: ok_bits = 32'h0000_0001;
      `PAC_ADDR_FLAGS:    ok_bits = 32'h0000_00ff;
      default:            ok_bits = 32'h0000_0000;
    endcase
  end

  // shadow of software settings, taken on the accepting edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q     <= 4'h0;
      mask_q    <= 1'b0;
      en_seen_q <= 1'b0;
    end else if (wr && word == `PAC_ADDR_CONFIG) begin
      cfg_q     <= wb_dat_i[3:0];
      en_seen_q <= en_seen_q | wb_dat_i[`PAC_CFG_ENABLE];
    end else if (wr && word == `PAC_ADDR_IRQ_MASK) begin
      mask_q    <= wb_dat_i[0];
    end
  end

  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && wb_dat_o == 32'h0 && gvec == 5'h0 && !irq_o)
    else $error("outputs active after reset");
  a_handover_gap: assert property (
    gvec != 5'h0 && gvec != $past(gvec) |-> $past(gvec) == 5'h0)
    else $error("grant moved without idle cycle");
  a_reserved_zero: assert property (
    wb_ack_o |-> (wb_dat_o & ~(wb_we_i ? 32'h0 : ok_bits)) == 32'h0)
    else $error("reserved read bits not zero");
  a_cfg_readback: assert property (
    wb_ack_o && !wb_we_i && word == `PAC_ADDR_CONFIG
    |-> wb_dat_o[3:0] == cfg_q)
    else $error("config read differs from last write");
  a_irq_masked: assert property (!$past(mask_q) |-> !irq_o)
    else $error("interrupt while masked");
  a_ext_gated: assert property (!en_seen_q |-> ext_gnt_n_o == 4'hf)
    else $error("external grant before enable");
  a_soft_idle: assert property (
    cfg_q[`PAC_CFG_SOFT_RESET] [*3] |-> gvec == 5'h0)
    else $error("grant during soft reset");

  c_irq_raised: cover property ($rose(irq_o));
  c_soft_held: cover property (cfg_q[`PAC_CFG_SOFT_RESET] [*3]);
  c_ext_grant: cover property (ext_gnt_n_o != 4'hf);
endmodule : pac_arbiter_checker

bind pac_arbiter pac_arbiter_checker u_checker (
  .clk_i (clk_i), .rst_i (rst_i), .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i), .wb_we_i (wb_we_i), .wb_adr_i (wb_adr_i),
  .wb_sel_i (wb_sel_i), .wb_dat_i (wb_dat_i), .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o), .int_gnt_o (int_gnt_o),
  .ext_gnt_n_o (ext_gnt_n_o), .irq_o (irq_o)
);

`default_nettype wire

// file: dv/test_pac_arbiter.sv
// self-checking bench for the arbiter control and status block
`timescale 1ns/100ps
`default_nettype none
`include "pac_regs.svh"

module test_pac_arbiter;
  logic        clk_i;
  logic        rst_i;
  logic [54:0] wb_req;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        int_req_i;
  logic        int_gnt_o;
  logic [3:0]  ext_req_n_i;
  logic [3:0]  ext_gnt_n_o;
  logic        frame_n_i;
  logic        irdy_n_i;
  logic        irq_o;
  logic [5:0]  obs;
  logic [3:0]  want;
  logic [31:0] port_map;
  logic        broken;
  int          fail_count;
  int          tests_run;

  // the whole request moves as one vector, so it changes in one step
  assign {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = wb_req;
  assign obs = {irq_o, int_gnt_o, ext_gnt_n_o};

  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // default mapping: a on the controller, z..w on request lines 0..3
  pac_arbiter dut (
    .clk_i (clk_i), .rst_i (rst_i), .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i), .wb_we_i (wb_we_i), .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i), .wb_dat_i (wb_dat_i), .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o), .int_req_i (int_req_i), .int_gnt_o (int_gnt_o),
    .ext_req_n_i (ext_req_n_i), .ext_gnt_n_o (ext_gnt_n_o),
    .frame_n_i (frame_n_i), .irdy_n_i (irdy_n_i),
    .request_port_map_i (port_map), .irq_o (irq_o)
  );

  pac_pci_masters partner (
    .clk_i (clk_i), .rst_i (rst_i), .want_i (want), .broken_i (broken),
    .ext_gnt_n_i (ext_gnt_n_o), .ext_req_n_o (ext_req_n_i),
    .frame_n_o (frame_n_i), .irdy_n_o (irdy_n_i)
  );

  task automatic finish_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : check

  // classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb_xfer(input logic we, input logic [15:0] adr,
                         input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    wb_req <= {1'b1, 1'b1, we, adr, 4'hf, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("wishbone ack", 32'h1, {31'h0, wb_ack_o});
    if (wb_ack_o !== 1'b1) finish_test();
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [15:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, d, unused);
  endtask : wr

  task automatic rd_chk(input string name, input logic [15:0] adr,
                        input logic [31:0] exp);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 32'h0, d);
    check(name, exp, d);
  endtask : rd_chk

  // bounded wait until the masked outputs match
  task automatic wait_obs(input string name, input logic [5:0] m,
                          input logic [5:0] exp);
    int n;
    n = 0;
    while ((obs & m) !== exp && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check(name, {26'h0, exp}, {26'h0, obs & m});
    if ((obs & m) !== exp) finish_test();
  endtask : wait_obs

  task automatic test_reset_values();
    rd_chk("config", `PAC_ADDR_CONFIG, 32'h0);
    rd_chk("status", `PAC_ADDR_STATUS, 32'h0);
    rd_chk("irq mask", `PAC_ADDR_IRQ_MASK, 32'h0);
    rd_chk("flags", `PAC_ADDR_FLAGS, 32'h0);
    wr(16'hd114, 32'hffff_ffff);
    rd_chk("unmapped", 16'hd114, 32'h0);
    wait_obs("park controller", 6'h3f, 6'h1f);
  endtask : test_reset_values

  task automatic test_enable_park();
    want <= 4'h1;
    repeat (20) @(posedge clk_i);
    check("disabled grant", 32'h1f, {26'h0, obs});
    wr(`PAC_ADDR_CONFIG, 32'hffff_fff2);
    rd_chk("config bits", `PAC_ADDR_CONFIG, 32'h2);
    wait_obs("grant line 0", 6'h3f, 6'h0e);
    want <= 4'h0;
    // let the transfer end and parking settle before judging it
    repeat (30) @(posedge clk_i);
    check("park last owner", 32'h0e, {26'h0, obs});
    wr(`PAC_ADDR_CONFIG, 32'ha);
    wait_obs("park port a", 6'h3f, 6'h1f);
  endtask : test_enable_park

  task automatic test_soft_reset();
    int_req_i <= 1'b1;
    wr(`PAC_ADDR_CONFIG, 32'he);
    wait_obs("soft reset grants", 6'h1f, 6'h0f);
    repeat (10) @(posedge clk_i);
    check("grants held", 32'h0f, {27'h0, obs[4:0]});
    rd_chk("soft bit kept", `PAC_ADDR_CONFIG, 32'he);
    wr(`PAC_ADDR_CONFIG, 32'ha);
    wait_obs("controller grant", 6'h1f, 6'h1f);
    int_req_i <= 1'b0;
  endtask : test_soft_reset

  task automatic test_broken_detect();
    wr(`PAC_ADDR_IRQ_MASK, 32'h1);
    broken <= 1'b1;
    want <= 4'h2;
    wr(`PAC_ADDR_CONFIG, 32'h3);
    wait_obs("broken irq", 6'h20, 6'h20);
    rd_chk("flag y", `PAC_ADDR_FLAGS, 32'h2);
    rd_chk("status", `PAC_ADDR_STATUS, 32'h1);
    check("y excluded", 32'h1, {31'h0, ext_gnt_n_o[1]});
    wr(`PAC_ADDR_STATUS, 32'h1);
    rd_chk("status held", `PAC_ADDR_STATUS, 32'h1);
    wr(`PAC_ADDR_IRQ_MASK, 32'h0);
    wait_obs("irq masked", 6'h20, 6'h00);
    want <= 4'h0;
    broken <= 1'b0;
    wr(`PAC_ADDR_FLAGS, 32'h0);
    wr(`PAC_ADDR_STATUS, 32'h0);
    rd_chk("write 0 kept", `PAC_ADDR_STATUS, 32'h1);
    wr(`PAC_ADDR_STATUS, 32'h1);
    rd_chk("status clear", `PAC_ADDR_STATUS, 32'h0);
    wr(`PAC_ADDR_IRQ_MASK, 32'h1);
    check("irq idle", 32'h0, {31'h0, irq_o});
  endtask : test_broken_detect

  task automatic test_check_disabled();
    broken <= 1'b1;
    want <= 4'h4;
    wr(`PAC_ADDR_CONFIG, 32'h2);
    wait_obs("grant line 2", 6'h0f, 6'h0b);
    repeat (40) @(posedge clk_i);
    rd_chk("no flag", `PAC_ADDR_FLAGS, 32'h0);
    wr(`PAC_ADDR_FLAGS, 32'h4);
    rd_chk("flag x", `PAC_ADDR_FLAGS, 32'h4);
    wait_obs("x dropped", 6'h0f, 6'h0f);
    repeat (20) @(posedge clk_i);
    check("x excluded", 32'h1, {31'h0, ext_gnt_n_o[2]});
    rd_chk("status soft", `PAC_ADDR_STATUS, 32'h1);
    wait_obs("irq soft", 6'h20, 6'h20);
    want <= 4'h0;
    broken <= 1'b0;
    wr(`PAC_ADDR_FLAGS, 32'h0);
    wr(`PAC_ADDR_STATUS, 32'h1);
    wait_obs("irq cleared", 6'h20, 6'h00);
  endtask : test_check_disabled

  // remap under soft reset so no grant jumps lines: a on line 3, w on ctrl
  task automatic test_remap();
    wr(`PAC_ADDR_CONFIG, 32'h6);
    port_map <= 32'h3654_7210;
    want <= 4'h8;
    wr(`PAC_ADDR_FLAGS, 32'h0);
    wr(`PAC_ADDR_CONFIG, 32'h2);
    wait_obs("a on line 3", 6'h3f, 6'h07);
    want <= 4'h0;
  endtask : test_remap

  initial begin
    fail_count = 0;
    tests_run = 0;
    rst_i = 1'b1;
    int_req_i = 1'b0;
    want = 4'h0;
    broken = 1'b0;
    port_map = 32'h7654_3210;
    wb_req = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset_values();
    test_enable_park();
    test_soft_reset();
    test_broken_detect();
    test_check_disabled();
    test_remap();
    finish_test();
  end
endmodule : test_pac_arbiter

`default_nettype wire
